/* File: hdl/timer_core.v */
// timer counting core with axi4-lite register slave and interrupt
// assumes count clock inputs are synchronous to mclk and sampled for edges
//
// Overview of operation
// - count clock picked from inverted input, sub-main, auxiliary or external
// - power-on reset or software clear bit forces the count to zero
// - first step after clear follows first count clock rising edge
// - that first step ignores both divider select bits
// - later steps are spaced by the selected divider ratio
// - up mode sets overflow flag on wrap from period value to zero
// - clear bit zeroes the count while stopped, no count clock needed
// - stopped at period, cleared, restarted: next edge falsely sets overflow
// - channel compare raised by one while count sits on it, before next step, loses following compare flag
`timescale 1ns/10ps
`include "timer_core_defines.vh"

module timer_core #(
    parameter CW = 16
) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // count clock sources
    input wire inverted_external_input_clock,
    input wire sub_main_system_clock,
    input wire auxiliary_clock,
    input wire external_count_clock,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // interrupt and status
    output reg irq,
    output reg [CW-1:0] count_value
);

function known;
    input [7:0] a;
    begin
        known = (a == `OFS_CTRL) || (a == `OFS_COUNT) ||
                (a == `OFS_PERIOD) || (a == `OFS_CHAN) ||
                (a == `OFS_STATUS) || (a == `OFS_MASK);
    end
endfunction

// word-aligned form of a bus byte address
function [7:0] align;
    input [7:0] a;
    begin
        align = {a[7:2], 2'b00};
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// registers

reg [6:0] ctrl_r;
reg [CW-1:0] period_compare_value;
reg [CW-1:0] channel_compare_value;
reg [2:0] status_r;
reg [2:0] mask_r;
reg [7:0] awaddr_r;
reg aw_held_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg w_held_r;
reg src_prev_r;
reg [2:0] div_cnt_r;
reg first_pending_r;
reg stopped_at_period_r;
reg false_ovf_armed_r;
reg chn_skip_r;

wire [1:0] divider_select = ctrl_r[`CTRL_DIV_HI:`CTRL_DIV_LO];
wire divider_select_low_bit = ctrl_r[`CTRL_DIV_LO];
wire divider_select_high_bit = ctrl_r[`CTRL_DIV_HI];
wire [1:0] mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
wire [1:0] src_sel = ctrl_r[`CTRL_SRC_HI:`CTRL_SRC_LO];
wire running = (mode == `MODE_UP);

////////////////////////////////////////////////////////////////////////////
// count clock selection and divider

// source 0 counts on the falling edge of its input
reg src_clk;
always @* begin
    case (src_sel)
        2'h0: src_clk = ~inverted_external_input_clock;
        2'h1: src_clk = sub_main_system_clock;
        2'h2: src_clk = auxiliary_clock;
        default: src_clk = external_count_clock;
    endcase
end

wire src_rise = src_clk & ~src_prev_r;

// divider ratios 1, 2, 4, 8 as a terminal count of source edges
reg [2:0] div_top;
always @* begin
    case ({divider_select_high_bit, divider_select_low_bit})
        2'h0: div_top = 3'h0;
        2'h1: div_top = 3'h1;
        2'h2: div_top = 3'h3;
        default: div_top = 3'h7;
    endcase
end

// first step after clear bypasses the divider
wire step = running && src_rise &&
            (first_pending_r || div_cnt_r == div_top);
wire at_period = (count_value == period_compare_value);

////////////////////////////////////////////////////////////////////////////
// axi4-lite handshake

// a held channel drops its ready until the write completes
wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
assign s_axi_awready = !aw_held_r;
assign s_axi_wready = !w_held_r;
assign s_axi_arready = !s_axi_rvalid;
wire rd_go = s_axi_arvalid && !s_axi_rvalid;
wire wr_ctrl = wr_go && awaddr_r == `OFS_CTRL && wstrb_r[0];
wire wr_count = wr_go && awaddr_r == `OFS_COUNT;
wire wr_period = wr_go && awaddr_r == `OFS_PERIOD;
wire wr_chan = wr_go && awaddr_r == `OFS_CHAN;
wire wr_mask = wr_go && awaddr_r == `OFS_MASK && wstrb_r[0];
wire wr_status = wr_go && awaddr_r == `OFS_STATUS && wstrb_r[0];
wire [7:0] rd_addr = align(s_axi_araddr);
wire clear_ev = wr_ctrl && wdata_r[`CTRL_CLEAR];
wire [CW-1:0] wcw = wdata_r[CW-1:0];

////////////////////////////////////////////////////////////////////////////
// counter and events

wire ev_ovf = step && (at_period || false_ovf_armed_r);
// compare against value in effect; a raised compare misses this step
wire ev_ch0 = step && (count_value + 1'b1 == period_compare_value);
// a compare raised while the count still sits on it skips one match
wire ev_chn = step && !chn_skip_r &&
              (count_value + 1'b1 == channel_compare_value);

always @(posedge mclk) begin
    if (!resetn) begin
        count_value <= {CW{1'b0}};
        src_prev_r <= 1'b0;
        div_cnt_r <= 3'h0;
        first_pending_r <= 1'b1;
        stopped_at_period_r <= 1'b0;
        false_ovf_armed_r <= 1'b0;
        chn_skip_r <= 1'b0;
    end else begin
        src_prev_r <= src_clk;
        if (clear_ev) begin
            count_value <= {CW{1'b0}};
            div_cnt_r <= 3'h0;
            first_pending_r <= 1'b1;
            false_ovf_armed_r <= stopped_at_period_r;
        end else if (wr_count) begin
            count_value <= wcw;
        end else if (step) begin
            first_pending_r <= 1'b0;
            false_ovf_armed_r <= 1'b0;
            div_cnt_r <= 3'h0;
            if (at_period)
                count_value <= {CW{1'b0}};
            else
                count_value <= count_value + 1'b1;
        end else if (running && src_rise) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
        // the raised compare loses the flag due on the next step
        if (wr_chan && count_value == channel_compare_value)
            chn_skip_r <= 1'b1;
        else if (step || clear_ev || wr_count)
            chn_skip_r <= 1'b0;
        // remember a stop on the period value for the false overflow
        if (!running)
            stopped_at_period_r <= stopped_at_period_r |
                                   (at_period && !clear_ev);
        else if (step)
            stopped_at_period_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// register writes, status and interrupt

always @(posedge mclk) begin
    if (!resetn) begin
        ctrl_r <= `CTRL_RST;
        period_compare_value <= `PERIOD_RST;
        channel_compare_value <= `CHAN_RST;
        status_r <= 3'h0;
        mask_r <= 3'h0;
        irq <= 1'b0;
    end else begin
        if (wr_ctrl)
            ctrl_r <= {wdata_r[6:1], 1'b0};
        if (wr_period)
            period_compare_value <= wcw;
        if (wr_chan)
            channel_compare_value <= wcw;
        if (wr_mask)
            mask_r <= wdata_r[2:0];
        // set wins over write-one-to-clear
        status_r <= (status_r &
                     ~(wr_status ? wdata_r[2:0] : 3'h0)) |
                    {ev_chn, ev_ch0, ev_ovf};
        // irq lags the status bits by one cycle
        irq <= |(status_r & mask_r);
    end
end

////////////////////////////////////////////////////////////////////////////
// register read selection

// unmapped addresses read as zero and answer slverr
reg [31:0] rd_word;
always @* begin
    rd_word = 32'h00000000;
    if (rd_addr == `OFS_CTRL)
        rd_word[6:0] = ctrl_r;
    else if (rd_addr == `OFS_COUNT)
        rd_word[CW-1:0] = count_value;
    else if (rd_addr == `OFS_PERIOD)
        rd_word[CW-1:0] = period_compare_value;
    else if (rd_addr == `OFS_CHAN)
        rd_word[CW-1:0] = channel_compare_value;
    else if (rd_addr == `OFS_STATUS)
        rd_word[2:0] = status_r;
    else if (rd_addr == `OFS_MASK)
        rd_word[2:0] = mask_r;
end

////////////////////////////////////////////////////////////////////////////
// bus channel capture and answers

always @(posedge mclk) begin
    if (!resetn) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h00000000;
        wstrb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'h0;
        s_axi_rdata <= 32'h00000000;
    end else begin
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            awaddr_r <= align(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known(awaddr_r) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= known(rd_addr) ? 2'h0 : 2'h2;
            s_axi_rdata <= rd_word;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule // timer_core

/* File: hdl/timer_core_defines.vh */
// timer counting core constants: register offsets, fields, reset values
// assumes byte addresses on an axi4-lite bus with 32-bit data
`ifndef TIMER_CORE_DEFINES_VH
`define TIMER_CORE_DEFINES_VH

`define OFS_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_PERIOD 8'h08
`define OFS_CHAN 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14

// control fields
`define CTRL_CLEAR 0
`define CTRL_DIV_LO 1
`define CTRL_DIV_HI 2
`define CTRL_MODE_LO 3
`define CTRL_MODE_HI 4
`define CTRL_SRC_LO 5
`define CTRL_SRC_HI 6

// status / mask fields
`define ST_OVF 0
`define ST_CH0 1
`define ST_CHN 2

`define MODE_STOP 2'h0
`define MODE_UP 2'h1

`define CTRL_RST 7'h00
`define PERIOD_RST 16'h0000
`define CHAN_RST 16'h0000

`endif

/* File: verif/timer_core_monitor.sv */
// checker for the timer core: bus answers and counter stepping
// assumes it is bound to timer_core, one clock domain on mclk
`timescale 1ns/10ps

module timer_core_monitor #(
    parameter CW = 16
) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] s_axi_rresp,
    // outputs
    input wire irq,
    input wire [CW-1:0] count_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////
    reset_state_a:
    assert property ($rose(resetn) |-> count_value == 0 && !irq)
        else $error("count or irq not clear after reset");
    count_step_a:
    assert property ($changed(count_value) && !$past(s_axi_wvalid)
        && !$past(s_axi_wvalid, 2)
        |-> count_value == $past(count_value) + 1'b1 || count_value == 0)
        else $error("count moved by other than one step or wrap");
    write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    bvalid_drop_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after taken");
    rvalid_drop_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after taken");
    read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    resp_code_a:
    assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0
        || s_axi_bresp == 2'h2)
        else $error("write response code illegal");
    cover property ($past(count_value) != 0 && count_value == 0);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // timer_core_monitor

/* File: verif/timer_core_tb.sv */
// self-checking bench for the timer core
// assumes timer_core and its defines header on the include path
`timescale 1ns/10ps
`include "timer_core_defines.vh"

module timer_core_tb;
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg [3:0] src = 4'h1;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg [7:0] s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] count_value;
    integer mismatches = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer sel = 0;
    ////////////////
    timer_core dut (
        .mclk, .resetn,
        .inverted_external_input_clock(src[0]),
        .sub_main_system_clock(src[1]),
        .auxiliary_clock(src[2]),
        .external_count_clock(src[3]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .irq, .count_value
    );
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cc(input [15:0] e);
        chk({16'h0, count_value}, {16'h0, e});
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, (a > `OFS_MASK) ? 2'h2 : 2'h0});
    endtask
    task rc(input [7:0] a, input [31:0] e, input [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // one active edge on the selected source per loop
    task tick(input integer n);
        repeat (n) begin
            @(posedge mclk);
            src <= src ^ (4'h1 << sel);
            repeat (3) @(posedge mclk);
            src <= src ^ (4'h1 << sel);
            repeat (3) @(posedge mclk);
        end
    endtask
    function [31:0] cw(input [1:0] dv, input [1:0] md, input [1:0] sr,
        input cl);
        cw = {25'h0, sr, md, dv, cl};
    endfunction
    ////////////////
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        cc(16'h0);
        rc(`OFS_CTRL, 32'h0, 2'h0);
        rc(8'h20, 32'h0, 2'h2);
        wr(8'h20, 32'h1);
        wr(`OFS_PERIOD, 32'h3);
        for (sel = 0; sel < 4; sel = sel + 1) begin
            wr(`OFS_CTRL, cw(sel[1:0], `MODE_UP, sel[1:0], 1'b1));
            tick(1);
            cc(16'h1);
            tick((1 << sel) - 1);
            cc(16'h1);
            tick(1);
            cc(16'h2);
        end
        sel = 1;
        wr(`OFS_CTRL, cw(2'h0, `MODE_UP, 2'h1, 1'b1));
        wr(`OFS_STATUS, 32'h7);
        tick(3);
        rc(`OFS_STATUS, 32'h2, 2'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_MASK, 32'h1);
        tick(1);
        cc(16'h0);
        rc(`OFS_STATUS, 32'h3, 2'h0);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_STATUS, 32'h1);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        tick(3);
        wr(`OFS_CTRL, cw(2'h0, `MODE_STOP, 2'h1, 1'b0));
        wr(`OFS_CTRL, cw(2'h0, `MODE_STOP, 2'h1, 1'b1));
        cc(16'h0);
        wr(`OFS_STATUS, 32'h7);
        wr(`OFS_CTRL, cw(2'h0, `MODE_UP, 2'h1, 1'b0));
        tick(1);
        rc(`OFS_STATUS, 32'h1, 2'h0);
        wr(`OFS_CHAN, 32'h2);
        tick(1);
        rc(`OFS_STATUS, 32'h5, 2'h0);
        wr(`OFS_STATUS, 32'h7);
        wr(`OFS_CHAN, 32'h3); // no capture switch first
        tick(1);
        rc(`OFS_STATUS, 32'h2, 2'h0);
        complete_run;
    end
endmodule // timer_core_tb

bind timer_core timer_core_monitor #(.CW(CW)) mon (
    .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rresp, .irq, .count_value
);
